// *** verilog/port_status_pkg.sv ***
// Functional notes
// - Each port holds a writable 3-bit speed limit, codes 000..101, 110 reserved.
// - A limit written above the port's capability stores the capability instead.
// - Stored limit is applied only on a new newer-mode link of exclusive ports.
// - Dual-mode ports run fixed at the 400 code; limit writes are ignored.
// - Limit resets to capability; software may lower it, never below minimum.
// - Local plug flag always reads 1.
// - Read-only field shows the port's highest newer-mode speed.
// - Link-failure flag sets on negotiation or sync failure; writing 1 clears it.
// - Newer-mode indication is 1 only while the port runs that mode.
// - Connected and receive-ok set with newer-mode clear means legacy mode is active.
// - Eight-bit bad-symbol counter increments per invalid code, saturating at 255.
// - Counter clears when read, locally or by a remote access.
// - Asleep flag shows sleep; sleep is entered only when sleep is allowed.
// - Sleep strap pin level is loaded into every port's sleep allow bit at reset.
// - In power-management mode without link, sleep states drive the link data lines.
// - Loop-blocked flag sets from the loop-free build, clears on bus reset or disconnect.
// - Standby flag reads 1 while the port is in standby.
// - Deep-off bit acts only while the port's disable control is set.
// - Deep-off forces connected and receive-ok to 0, stops connectivity tracking.
// - Deep-off port stops sending connection tones.
// - Disabled port never becomes active but keeps toning unless deep-off is set; disable resets to 0.
// - Connected sets after about 341 ms of stable connection; hardware reset clears it.
package port_status_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_SEL = 8'h00;
    localparam logic [7:0] ADDR_SPEED = 8'h04;
    localparam logic [7:0] ADDR_ERR = 8'h08;
    localparam logic [7:0] ADDR_PWR = 8'h0c;
    localparam logic [7:0] ADDR_MODE = 8'h10;

    // speed codes
    localparam logic [2:0] SPD_S100 = 3'h0;
    localparam logic [2:0] SPD_S200 = 3'h1;
    localparam logic [2:0] SPD_S400 = 3'h2;
    localparam logic [2:0] SPD_S800 = 3'h3;
    localparam logic [2:0] SPD_S1600 = 3'h4;
    localparam logic [2:0] SPD_S3200 = 3'h5;
    localparam logic [2:0] SPD_RSVD = 3'h6;

    // speed register fields
    localparam int SPD_LIMIT_LSB = 0;
    localparam int SPD_CAP_LSB = 4;
    localparam int SPD_PLUG_BIT = 8;
    localparam int SPD_FAIL_BIT = 12;
    localparam int SPD_NEWER_BIT = 16;

    // power register fields
    localparam int PWR_ALLOW_BIT = 0;
    localparam int PWR_ASLEEP_BIT = 1;
    localparam int PWR_LOOP_BIT = 2;
    localparam int PWR_STANDBY_BIT = 3;
    localparam int PWR_DEEP_BIT = 4;
    localparam int PWR_DIS_BIT = 5;
    localparam int PWR_CONN_BIT = 8;
    localparam int PWR_RX_OK_BIT = 9;

    // mode register field
    localparam int MODE_PM_CTRL_BIT = 0;

    localparam logic [7:0] ERR_MAX = 8'hff;
    localparam logic PLUG_VALUE = 1'b1;
    localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;

    // connection debounce
    localparam int unsigned DEBOUNCE_MS = 341;
    localparam longint unsigned CLK_HZ = 64'd10_000_000;
    localparam int unsigned DEBOUNCE_CYCLES =
        32'((longint'(DEBOUNCE_MS) * CLK_HZ + 64'd999) / 64'd1000);

    // per-port events from the port core
    typedef struct packed {
        logic conn_raw;
        logic rx_raw;
        logic newer_mode;
        logic new_conn;
        logic neg_fail;
        logic bad_symbol;
        logic remote_rd_clr;
        logic sleep_req;
        logic loop_block;
        logic bus_reset;
        logic standby;
    } port_evt_t;

endpackage

// *** verilog/port_status_page_fields.sv ***
`timescale 1ns/1ps
module port_status_page_fields #(
    parameter int NUM_PORTS = 3,
    parameter logic [2:0] CAP_SPEED = port_status_pkg::SPD_S400,
    parameter logic [2:0] MIN_SPEED = port_status_pkg::SPD_S100,
    parameter int unsigned DEBOUNCE_CYCLES = port_status_pkg::DEBOUNCE_CYCLES,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // pins
    input wire logic sleep_strap_pin,
    input wire logic link_present_pin,
    input wire logic [NUM_PORTS-1:0] port_dual_mode_pin,
    // port core events
    input wire port_status_pkg::port_evt_t core_evt [NUM_PORTS],
    // port control
    output logic [NUM_PORTS-1:0] port_enable_allow,
    output logic [NUM_PORTS-1:0] tone_enable,
    output logic [NUM_PORTS-1:0] connected,
    output logic [NUM_PORTS-1:0] receive_ok_indication,
    output logic [2:0] train_speed [NUM_PORTS],
    // link data lines in power-management mode
    output logic [NUM_PORTS-1:0] link_clock_pm_pin_o,
    output logic [NUM_PORTS-1:0] link_clock_pm_pin_oe
);

    localparam int SEL_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
    localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // synchronised pins
    logic strap_meta_q, strap_q;
    logic link_meta_q, link_q;
    logic [NUM_PORTS-1:0] dual_meta_q, dual_q;

    // shared control
    logic [SEL_W-1:0] sel_q;
    logic power_management_control_mode_q;
    logic [1:0] strap_cnt_q;
    logic strap_load;
    logic [31:0] prdata_q;
    logic [31:0] rd_word;
    logic [7:0] addr;
    logic mapped;
    logic setup, apb_wr, apb_rd;

    // per-port fields
    logic [2:0] limit_q [NUM_PORTS];
    logic [2:0] train_q [NUM_PORTS];
    logic [7:0] err_q [NUM_PORTS];
    logic [NUM_PORTS-1:0] fail_q, newer_q, allow_q, asleep_q, loop_q;
    logic [NUM_PORTS-1:0] standby_q, deep_q, dis_q, conn_q, rx_ok_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_meta_q <= 1'b0;
            strap_q <= 1'b0;
            link_meta_q <= 1'b0;
            link_q <= 1'b0;
            dual_meta_q <= '0;
            dual_q <= '0;
        end
        else
        begin
            strap_meta_q <= sleep_strap_pin;
            strap_q <= strap_meta_q;
            link_meta_q <= link_present_pin;
            link_q <= link_meta_q;
            dual_meta_q <= port_dual_mode_pin;
            dual_q <= dual_meta_q;
        end
    end

    // apb decode
    assign addr = paddr[7:0];
    assign mapped = (paddr[ADDR_W-1:0] == ADDR_W'(addr)) &&
        (addr == port_status_pkg::ADDR_SEL || addr == port_status_pkg::ADDR_SPEED ||
         addr == port_status_pkg::ADDR_ERR || addr == port_status_pkg::ADDR_PWR ||
         addr == port_status_pkg::ADDR_MODE);
    assign setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite && mapped;
    assign apb_rd = psel && penable && !pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // strap is caught once the synchroniser has settled after release
    assign strap_load = (strap_cnt_q == port_status_pkg::STRAP_LOAD_CNT);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strap_cnt_q <= 2'h0;
        else if (strap_cnt_q <= port_status_pkg::STRAP_LOAD_CNT)
            strap_cnt_q <= strap_cnt_q + 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sel_q <= '0;
        else if (apb_wr && addr == port_status_pkg::ADDR_SEL && pwdata < 32'(NUM_PORTS))
            sel_q <= pwdata[SEL_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            power_management_control_mode_q <= 1'b0;
        else if (apb_wr && addr == port_status_pkg::ADDR_MODE)
            power_management_control_mode_q <= pwdata[port_status_pkg::MODE_PM_CTRL_BIT];
    end

    // read word of the selected port
    always_comb
    begin
        rd_word = 32'h0;
        case (addr)
            port_status_pkg::ADDR_SEL:
                rd_word[SEL_W-1:0] = sel_q;
            port_status_pkg::ADDR_SPEED:
            begin
                rd_word[port_status_pkg::SPD_LIMIT_LSB +: 3] = limit_q[sel_q];
                rd_word[port_status_pkg::SPD_CAP_LSB +: 3] = CAP_SPEED;
                rd_word[port_status_pkg::SPD_PLUG_BIT] = port_status_pkg::PLUG_VALUE;
                rd_word[port_status_pkg::SPD_FAIL_BIT] = fail_q[sel_q];
                rd_word[port_status_pkg::SPD_NEWER_BIT] = newer_q[sel_q];
            end
            port_status_pkg::ADDR_ERR:
                rd_word[7:0] = err_q[sel_q];
            port_status_pkg::ADDR_PWR:
            begin
                rd_word[port_status_pkg::PWR_ALLOW_BIT] = allow_q[sel_q];
                rd_word[port_status_pkg::PWR_ASLEEP_BIT] = asleep_q[sel_q];
                rd_word[port_status_pkg::PWR_LOOP_BIT] = loop_q[sel_q];
                rd_word[port_status_pkg::PWR_STANDBY_BIT] = standby_q[sel_q];
                rd_word[port_status_pkg::PWR_DEEP_BIT] = deep_q[sel_q];
                rd_word[port_status_pkg::PWR_DIS_BIT] = dis_q[sel_q];
                rd_word[port_status_pkg::PWR_CONN_BIT] = conn_q[sel_q];
                rd_word[port_status_pkg::PWR_RX_OK_BIT] = rx_ok_q[sel_q];
            end
            port_status_pkg::ADDR_MODE:
                rd_word[port_status_pkg::MODE_PM_CTRL_BIT] = power_management_control_mode_q;
            default:
                rd_word = 32'h0;
        endcase
    end

    // read data sampled in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0;
        else if (setup && !pwrite)
            prdata_q <= mapped ? rd_word : 32'h0;
    end

    genvar i;
    generate
        for (i = 0; i < NUM_PORTS; i++)
        begin : g_port
            logic hit;
            logic hard_off;
            logic rd_clr;
            logic [7:0] err_base;
            logic [DB_W-1:0] db_q;

            assign hit = (sel_q == SEL_W'(i));
            assign hard_off = dis_q[i] && deep_q[i];
            assign rd_clr = apb_rd && hit && addr == port_status_pkg::ADDR_ERR;
            // read-clear removes only what was returned, keeping later counts
            assign err_base = rd_clr ? err_q[i] - prdata_q[7:0] :
                (core_evt[i].remote_rd_clr ? 8'h0 : err_q[i]);

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    limit_q[i] <= CAP_SPEED;
                else if (apb_wr && hit && addr == port_status_pkg::ADDR_SPEED && !dual_q[i])
                begin
                    if (pwdata[2:0] > CAP_SPEED)
                        limit_q[i] <= CAP_SPEED;
                    else if (pwdata[2:0] < MIN_SPEED)
                        limit_q[i] <= MIN_SPEED;
                    else
                        limit_q[i] <= pwdata[2:0];
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    train_q[i] <= CAP_SPEED;
                else if (dual_q[i])
                    train_q[i] <= port_status_pkg::SPD_S400;
                else if (core_evt[i].new_conn && core_evt[i].newer_mode)
                    train_q[i] <= limit_q[i];
            end
            assign train_speed[i] = train_q[i];

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    fail_q[i] <= 1'b0;
                else if (core_evt[i].neg_fail)
                    fail_q[i] <= 1'b1;
                else if (apb_wr && hit && addr == port_status_pkg::ADDR_SPEED &&
                         pwdata[port_status_pkg::SPD_FAIL_BIT])
                    fail_q[i] <= 1'b0;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    err_q[i] <= 8'h0;
                else if (core_evt[i].bad_symbol && err_base != port_status_pkg::ERR_MAX)
                    err_q[i] <= err_base + 8'h1;
                else
                    err_q[i] <= err_base;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    allow_q[i] <= 1'b0;
                else if (strap_load)
                    allow_q[i] <= strap_q;
                else if (apb_wr && hit && addr == port_status_pkg::ADDR_PWR)
                    allow_q[i] <= pwdata[port_status_pkg::PWR_ALLOW_BIT];
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    asleep_q[i] <= 1'b0;
                    standby_q[i] <= 1'b0;
                end
                else
                begin
                    asleep_q[i] <= core_evt[i].sleep_req && allow_q[i];
                    standby_q[i] <= core_evt[i].standby;
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    loop_q[i] <= 1'b0;
                else if (core_evt[i].loop_block)
                    loop_q[i] <= 1'b1;
                else if (core_evt[i].bus_reset || !core_evt[i].conn_raw)
                    loop_q[i] <= 1'b0;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    dis_q[i] <= 1'b0;
                    deep_q[i] <= 1'b0;
                end
                else if (apb_wr && hit && addr == port_status_pkg::ADDR_PWR)
                begin
                    dis_q[i] <= pwdata[port_status_pkg::PWR_DIS_BIT];
                    deep_q[i] <= pwdata[port_status_pkg::PWR_DEEP_BIT];
                end
            end

            // connection debounce, cleared to zero while deep-off or without raw connection
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    db_q <= '0;
                    conn_q[i] <= 1'b0;
                end
                else if (hard_off || !core_evt[i].conn_raw)
                begin
                    db_q <= '0;
                    conn_q[i] <= 1'b0;
                end
                else if (db_q == DB_LAST)
                    conn_q[i] <= 1'b1;
                else
                    db_q <= db_q + DB_W'(1);
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    rx_ok_q[i] <= 1'b0;
                    newer_q[i] <= 1'b0;
                end
                else
                begin
                    rx_ok_q[i] <= core_evt[i].rx_raw && !hard_off;
                    newer_q[i] <= core_evt[i].newer_mode && core_evt[i].conn_raw && !hard_off;
                end
            end

            // legacy mode is conn and rx ok without newer mode
            assign connected[i] = conn_q[i];
            assign receive_ok_indication[i] = rx_ok_q[i];
            assign port_enable_allow[i] = !dis_q[i];
            assign tone_enable[i] = !hard_off;
            assign link_clock_pm_pin_o[i] = asleep_q[i];
            assign link_clock_pm_pin_oe[i] = power_management_control_mode_q && !link_q;

            sequence s_speed_write_high;
                apb_wr && hit && addr == port_status_pkg::ADDR_SPEED && !dual_q[i] && pwdata[2:0] > CAP_SPEED;
            endsequence

            a_speed_clamp: assert property (s_speed_write_high |=> limit_q[i] == CAP_SPEED)
                else $error("speed limit not clamped to capability");
            a_dual_fixed: assert property (dual_q[i] |=> train_q[i] == port_status_pkg::SPD_S400)
                else $error("dual-mode port left the 400 code");
            a_fail_set: assert property (core_evt[i].neg_fail |=> fail_q[i] ##1 fail_q[i] || $past(apb_wr))
                else $error("failure flag lost");
            a_err_saturate: assert property (err_q[i] == port_status_pkg::ERR_MAX && !rd_clr &&
                !core_evt[i].remote_rd_clr |=> err_q[i] == port_status_pkg::ERR_MAX)
                else $error("bad-symbol counter wrapped");
            a_err_remote_clear: assert property (core_evt[i].remote_rd_clr && !rd_clr &&
                !core_evt[i].bad_symbol |=> err_q[i] == 8'h0)
                else $error("remote read did not clear counter");
            a_sleep_gate: assert property (asleep_q[i] |-> $past(allow_q[i]))
                else $error("sleep entered without allow");
            a_loop_clear: assert property (core_evt[i].bus_reset && !core_evt[i].loop_block |=> !loop_q[i])
                else $error("loop flag survived bus reset");
            sequence s_hard_off_drop;
                !tone_enable[i] ##1 (!conn_q[i] && !rx_ok_q[i]);
            endsequence

            sequence s_new_link;
                core_evt[i].new_conn && core_evt[i].newer_mode && !dual_q[i];
            endsequence

            sequence s_local_clear;
                rd_clr && err_q[i] == prdata_q[7:0] && !core_evt[i].bad_symbol && !core_evt[i].remote_rd_clr;
            endsequence

            a_hard_off: assert property (hard_off |-> s_hard_off_drop)
                else $error("deep-off port still shows connection");
            a_train_apply: assert property (s_new_link |=> train_q[i] == $past(limit_q[i]))
                else $error("stored limit not applied on new link");
            a_err_read_clear: assert property (s_local_clear |=> err_q[i] == 8'h0)
                else $error("read did not clear counter");
            a_conn_debounce: assert property ($rose(conn_q[i]) |-> $past(db_q) == DB_LAST &&
                $past(core_evt[i].conn_raw))
                else $error("connected set before debounce");
        end
    endgenerate

    a_strap_load: assert property (strap_load |=> allow_q == {NUM_PORTS{$past(strap_q)}})
        else $error("sleep allow not loaded from strap");

    a_sel_range: assert property (32'(sel_q) < NUM_PORTS)
        else $error("port select out of range");

endmodule // port_status_page_fields

// *** test/peer_phy_model.sv ***
`timescale 1ns/1ps
module peer_phy_model #(
    parameter int NUM_PORTS = 3
) (
    // clock
    input wire logic pclk,
    // events seen from the cable
    output port_status_pkg::port_evt_t core_evt [NUM_PORTS]
);
    initial
    begin
        for (int i = 0; i < NUM_PORTS; i++)
            core_evt[i] = '0;
    end

    // changes land just after an edge and stand until changed again
    task automatic drive(input int p, input port_status_pkg::port_evt_t m, input logic v);
        @(posedge pclk);
        core_evt[p] <= v ? (core_evt[p] | m) : (core_evt[p] & ~m);
    endtask

    // one-cycle event, as a peer reports a single occurrence
    task automatic pulse(input int p, input port_status_pkg::port_evt_t m);
        drive(p, m, 1'b1);
        drive(p, m, 1'b0);
    endtask
endmodule // peer_phy_model

// *** test/test_port_status_page_fields.sv ***
`timescale 1ns/1ps
module test_port_status_page_fields;
    localparam int NP = 3;
    typedef port_status_pkg::port_evt_t evt_t;
    localparam evt_t E_CONN = evt_t'(11'h600);
    localparam evt_t E_NEW = evt_t'(11'h100);
    localparam evt_t E_NC = evt_t'(11'h080);
    localparam evt_t E_FAIL = evt_t'(11'h040);
    localparam evt_t E_BAD = evt_t'(11'h020);
    localparam evt_t E_RCLR = evt_t'(11'h010);
    localparam evt_t E_SLP = evt_t'(11'h008);
    localparam evt_t E_LOOP = evt_t'(11'h004);
    localparam evt_t E_BRST = evt_t'(11'h002);
    localparam evt_t E_STBY = evt_t'(11'h001);
    localparam logic [7:0] A_SEL = port_status_pkg::ADDR_SEL;
    localparam logic [7:0] A_SPD = port_status_pkg::ADDR_SPEED;
    localparam logic [7:0] A_ERR = port_status_pkg::ADDR_ERR;
    localparam logic [7:0] A_PWR = port_status_pkg::ADDR_PWR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, err;
    logic [31:0] prdata, rd;
    logic strap = 1'b1;
    logic link = 1'b0;
    logic [NP-1:0] dual = 3'h4;
    evt_t core_evt [NP];
    logic [NP-1:0] allow, tone, conn, rx_ok, pm_o, pm_oe;
    logic [2:0] train [NP];
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    port_status_page_fields #(.NUM_PORTS(NP), .CAP_SPEED(port_status_pkg::SPD_S800), .DEBOUNCE_CYCLES(8))
        dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sleep_strap_pin(strap), .link_present_pin(link),
        .port_dual_mode_pin(dual), .core_evt(core_evt), .port_enable_allow(allow), .tone_enable(tone),
        .connected(conn), .receive_ok_indication(rx_ok), .train_speed(train), .link_clock_pm_pin_o(pm_o),
        .link_clock_pm_pin_oe(pm_oe));
    peer_phy_model #(.NUM_PORTS(NP)) peer (.pclk(pclk), .core_evt(core_evt));

    initial
    begin
        forever #50 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            $display("ERROR %0t: run took too long", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // setup, then access held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask

    task automatic t_reset();
        for (int p = 0; p < NP; p++)
        begin
            apb(1'b1, A_SEL, p);
            rdchk(A_SPD, 32'hffffffff, 32'h00000133);
            rdchk(A_PWR, 32'h00000001, 32'h00000001);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_speed();
        apb(1'b1, A_SEL, 32'h0);
        for (int c = 0; c < 7; c++)
        begin
            apb(1'b1, A_SPD, c);
            rdchk(A_SPD, 32'h7, (c > 3) ? 32'h3 : c);
        end
        apb(1'b1, A_SPD, 32'h1);
        cyc(1);
        chk(train[0], 3'h3);
        peer.drive(0, E_NEW, 1'b1);
        peer.pulse(0, E_NC);
        cyc(2);
        chk(train[0], 3'h1);
        apb(1'b1, A_SEL, 32'h2);
        apb(1'b1, A_SPD, 32'h0);
        rdchk(A_SPD, 32'h7, 32'h3);
        peer.pulse(2, E_NC);
        cyc(2);
        chk(train[2], 3'h2);
        apb(1'b1, A_SEL, 32'h3);
        rdchk(A_SEL, 32'h3, 32'h2);
        apb(1'b1, A_SEL, 32'h1);
        rdchk(A_SPD, 32'h7, 32'h3);
        $display("test speed done");
    endtask

    task automatic t_fail_count();
        apb(1'b1, A_SEL, 32'h0);
        peer.pulse(0, E_FAIL);
        rdchk(A_SPD, 32'h1000, 32'h1000);
        apb(1'b1, A_SPD, 32'h1001);
        rdchk(A_SPD, 32'h1000, 32'h0);
        peer.drive(0, E_BAD, 1'b1);
        repeat (260) @(posedge pclk);
        peer.drive(0, E_BAD, 1'b0);
        rdchk(A_ERR, 32'hffffffff, 32'hff);
        rdchk(A_ERR, 32'hffffffff, 32'h0);
        for (int i = 0; i < 3; i++)
            peer.pulse(0, E_BAD);
        rdchk(A_ERR, 32'hff, 32'h3);
        for (int i = 0; i < 3; i++)
            peer.pulse(0, E_BAD);
        peer.pulse(0, E_RCLR);
        rdchk(A_ERR, 32'hff, 32'h0);
        $display("test failure and counter done");
    endtask

    task automatic t_conn();
        peer.drive(0, E_CONN, 1'b1);
        cyc(7);
        chk(conn[0], 1'b0);
        cyc(1);
        chk({conn[0], rx_ok[0]}, 2'h3);
        rdchk(A_SPD, 32'h10000, 32'h10000);
        peer.drive(0, E_NEW, 1'b0);
        rdchk(A_SPD, 32'h10000, 32'h0);
        rdchk(A_PWR, 32'h300, 32'h300);
        apb(1'b1, A_PWR, 32'h11);
        cyc(2);
        chk({tone[0], conn[0], allow[0]}, 3'h7);
        apb(1'b1, A_PWR, 32'h31);
        cyc(2);
        chk({tone[0], conn[0], rx_ok[0], allow[0]}, 4'h0);
        apb(1'b1, A_PWR, 32'h21);
        cyc(2);
        chk({tone[0], allow[0]}, 2'h2);
        apb(1'b1, A_PWR, 32'h01);
        $display("test connection done");
    endtask

    task automatic t_power();
        peer.pulse(0, E_LOOP);
        rdchk(A_PWR, 32'h4, 32'h4);
        peer.pulse(0, E_BRST);
        rdchk(A_PWR, 32'h4, 32'h0);
        peer.drive(0, E_STBY, 1'b1);
        rdchk(A_PWR, 32'h8, 32'h8);
        peer.drive(0, E_STBY, 1'b0);
        peer.drive(0, E_SLP, 1'b1);
        apb(1'b1, port_status_pkg::ADDR_MODE, 32'h1);
        cyc(4);
        chk({pm_oe[0], pm_o[0]}, 2'h3);
        rdchk(A_PWR, 32'h2, 32'h2);
        apb(1'b1, A_PWR, 32'h0);
        rdchk(A_PWR, 32'h3, 32'h0);
        @(posedge pclk);
        link <= 1'b1;
        cyc(4);
        chk(pm_oe[0], 1'b0);
        $display("test power done");
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cyc(5);
        t_reset();
        t_speed();
        t_fail_count();
        t_conn();
        t_power();
        tally_and_finish();
    end
endmodule // test_port_status_page_fields
